// ==== hdl/mlsr_top.sv ====
// multi-lane static shift register with input sample buffer
//
// Notes on behaviour
// - two four-stage and two five-stage lanes
// - one shared shift clock drives all lanes
// - shift only on falling shift clock edge
// - each lane loads its serial input first
// - bits move one stage, last is dropped
// - short lanes show their final stage
// - long lanes show fourth and fifth stages
`timescale 1ns/1ps
`default_nettype none
`include "mlsr_defines.svh"

// ************************************************************
// sample buffer
// ************************************************************
module mlsr_fifo #(
  parameter int WIDTH = `MLSR_LANES,
  parameter int DEPTH = `MLSR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // handshakes on both sides
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  // storage write
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  // count and registered full and empty flags
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count       <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      count       <= next_count;
      o_in_ready  <= (next_count != (AW+1)'(DEPTH));
      o_out_valid <= (next_count != '0);
    end
  end

  // ************************************************************
  // buffer checks
  // ************************************************************
  chk_no_overflow: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (count == (AW+1)'(DEPTH)) |-> !o_in_ready)
    else $error("buffer full but still ready");

  chk_no_underflow: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (count == '0) |-> !o_out_valid)
    else $error("buffer empty but still valid");

  chk_push_counted: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (push && !pop) |=> count == $past(count) + (AW+1)'(1))
    else $error("push did not raise the occupancy by one");

  chk_pop_counted: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (pop && !push) |=> count == $past(count) - (AW+1)'(1))
    else $error("pop did not lower the occupancy by one");
endmodule

// ************************************************************
// shift lanes
// ************************************************************
module mlsr_top (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // shared shift clock pin, shifts on its falling edge
  input  wire logic i_shift_clock_n,
  // serial data pins
  input  wire logic i_lane_a_serial_in,
  input  wire logic i_lane_b_serial_in,
  input  wire logic i_lane_c_serial_in,
  input  wire logic i_lane_d_serial_in,
  // stall of the shift engine
  input  wire logic i_shift_hold,
  // taps
  output logic      o_lane_a_last_out,
  output logic      o_lane_b_last_out,
  output logic      o_lane_c_fourth_tap,
  output logic      o_lane_c_fifth_tap,
  output logic      o_lane_d_fourth_tap,
  output logic      o_lane_d_fifth_tap,
  // buffer can take another edge sample
  output logic      o_sample_ready
);
  localparam int SL = `MLSR_SHORT_LEN;
  localparam int LL = `MLSR_LONG_LEN;

  logic                sclk_meta;
  logic                sclk_sync;
  logic                sclk_prev;
  mlsr_pkg::mlsr_word_t din_meta;
  mlsr_pkg::mlsr_word_t din_sync;
  logic                fall;
  logic                fifo_ready;
  logic                word_valid;
  mlsr_pkg::mlsr_word_t word;
  logic                pop;
  mlsr_pkg::mlsr_short_t lane_a;
  mlsr_pkg::mlsr_short_t lane_b;
  mlsr_pkg::mlsr_long_t  lane_c;
  mlsr_pkg::mlsr_long_t  lane_d;

  // one stage advance: new bit in low end, top bit dropped
  function automatic mlsr_pkg::mlsr_long_t shift_in(
    input mlsr_pkg::mlsr_long_t v,
    input logic                 b
  );
    shift_in = {v[LL-2:0], b};
  endfunction

  // two-flop synchronisers for pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      din_meta  <= `MLSR_SYNC_RST;
      din_sync  <= `MLSR_SYNC_RST;
    end else begin
      sclk_meta <= i_shift_clock_n;
      sclk_sync <= sclk_meta;
      din_meta  <= {i_lane_d_serial_in, i_lane_c_serial_in,
                    i_lane_b_serial_in, i_lane_a_serial_in};
      din_sync  <= din_meta;
    end
  end

  // edge history of the synchronised shift clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_sync;
    end
  end

  // only a high-to-low transition samples the lanes
  assign fall = sclk_prev && !sclk_sync;

  // edge samples queue up until the engine takes them
  mlsr_fifo #(
    .WIDTH (`MLSR_LANES),
    .DEPTH (`MLSR_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (fall),
    .i_in_data   (din_sync),
    .o_in_ready  (fifo_ready),
    .o_out_valid (word_valid),
    .o_out_data  (word),
    .i_out_ready (!i_shift_hold)
  );

  // one popped sample advances every lane at once
  assign pop = word_valid && !i_shift_hold;

  // lane storage; cleared only so outputs start known
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lane_a <= SL'(`MLSR_LANE_RST);
      lane_b <= SL'(`MLSR_LANE_RST);
      lane_c <= `MLSR_LANE_RST;
      lane_d <= `MLSR_LANE_RST;
    end else if (pop) begin
      // serial input enters first stage, rest moves on
      lane_a <= SL'(shift_in(LL'(lane_a), word[`MLSR_BIT_A]));
      lane_b <= SL'(shift_in(LL'(lane_b), word[`MLSR_BIT_B]));
      lane_c <= shift_in(lane_c, word[`MLSR_BIT_C]);
      lane_d <= shift_in(lane_d, word[`MLSR_BIT_D]);
    end
  end

  // taps straight from lane flops
  assign o_lane_a_last_out   = lane_a[SL-1];
  assign o_lane_b_last_out   = lane_b[SL-1];
  assign o_lane_c_fourth_tap = lane_c[LL-2];
  assign o_lane_c_fifth_tap  = lane_c[LL-1];
  assign o_lane_d_fourth_tap = lane_d[LL-2];
  assign o_lane_d_fifth_tap  = lane_d[LL-1];
  assign o_sample_ready      = fifo_ready;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  chk_short_depth: assert property (
    pop [*4] |=> o_lane_a_last_out == $past(word[`MLSR_BIT_A], 4))
    else $error("lane a does not delay by four shifts");

  chk_long_depth: assert property (
    pop [*5] |=> o_lane_c_fifth_tap == $past(word[`MLSR_BIT_C], 5))
    else $error("lane c does not delay by five shifts");

  chk_common_shift: assert property (
    pop |=> (o_lane_b_last_out == $past(lane_b[SL-2]))
         && (o_lane_d_fifth_tap == $past(o_lane_d_fourth_tap)))
    else $error("lanes did not advance together");

  chk_idle_hold: assert property (
    !pop |=> $stable(lane_a) && $stable(lane_b)
          && $stable(lane_c) && $stable(lane_d))
    else $error("lane changed without a falling edge");

  chk_fall_sampled: assert property (
    (fall && fifo_ready) |=> word_valid)
    else $error("falling edge sample not queued");

  chk_first_stage: assert property (
    pop |=> lane_d[0] == $past(word[`MLSR_BIT_D]))
    else $error("serial input not loaded in first stage");

  chk_stage_move: assert property (
    pop |=> lane_c[LL-1:1] == $past(lane_c[LL-2:0]))
    else $error("stages did not move one position");

  chk_tap_pair: assert property (
    pop |=> o_lane_c_fifth_tap == $past(o_lane_c_fourth_tap))
    else $error("fourth tap did not feed fifth tap");

  chk_lane_b_depth: assert property (
    pop [*4] |=> o_lane_b_last_out == $past(word[`MLSR_BIT_B], 4))
    else $error("lane b does not delay by four shifts");

  chk_lane_d_depth: assert property (
    pop [*5] |=> o_lane_d_fifth_tap == $past(word[`MLSR_BIT_D], 5))
    else $error("lane d does not delay by five shifts");

  chk_fourth_delay: assert property (
    pop [*4] |=> o_lane_c_fourth_tap == $past(word[`MLSR_BIT_C], 4))
    else $error("lane c fourth tap not four shifts late");

  chk_short_entry: assert property (
    pop |=> lane_a[0] == $past(word[`MLSR_BIT_A]))
    else $error("lane a first stage missed its input");

  chk_short_move: assert property (
    pop |=> lane_a[SL-1:1] == $past(lane_a[SL-2:0]))
    else $error("lane a stages did not move one position");

  cov_fall_seen: cover property (fall ##1 word_valid);
  cov_edge_dropped: cover property (fall && !fifo_ready);
  cov_buffer_full: cover property (!fifo_ready);
  cov_long_run: cover property (pop [*5]);
  cov_held_stall: cover property (word_valid && i_shift_hold);
endmodule
`default_nettype wire

// ==== hdl/mlsr_defines.svh ====
// constants for the multi-lane static shift register
`ifndef MLSR_DEFINES_SVH
`define MLSR_DEFINES_SVH
// ************************************************************
// lane geometry
// ************************************************************
`define MLSR_SHORT_LEN  4
`define MLSR_LONG_LEN   5
`define MLSR_LANES      4
// ************************************************************
// lane bit positions inside a captured input word
// ************************************************************
`define MLSR_BIT_A      0
`define MLSR_BIT_B      1
`define MLSR_BIT_C      2
`define MLSR_BIT_D      3
// ************************************************************
// buffering and reset values
// ************************************************************
`define MLSR_FIFO_DEPTH 16
`define MLSR_LANE_RST   5'h0_0
`define MLSR_SYNC_RST   4'h0
`endif

// ==== hdl/mlsr_pkg.sv ====
// types shared by the multi-lane static shift register
`include "mlsr_defines.svh"
package mlsr_pkg;
  // one sampled bit per lane, lane a in bit 0
  typedef logic [`MLSR_LANES-1:0]     mlsr_word_t;
  // storage of a short and of a long lane
  typedef logic [`MLSR_SHORT_LEN-1:0] mlsr_short_t;
  typedef logic [`MLSR_LONG_LEN-1:0]  mlsr_long_t;
endpackage

// ==== verification/mlsr_sys_driver.sv ====
// system-side model that drives the shift clock and serial data pins
`timescale 1ns/1ps
`default_nettype none
module mlsr_sys_driver (
  // clock
  input  wire logic       i_clk_sys,
  // pins toward the shift lanes
  output logic            o_shift_clock_n,
  output logic      [3:0] o_serial
);
  // ************************************************************
  // idle levels and one shift cycle
  // ************************************************************
  // clock idles high so that the first low phase is a true fall
  initial begin
    o_shift_clock_n = 1'b1;
    o_serial        = 4'h0;
  end

  // data settles, the clock falls, then data turns over on the rise
  task automatic shift_word(input logic [3:0] w, input int slow);
    @(posedge i_clk_sys);
    o_serial <= w; // each lane fed on its own
    repeat (4 + slow) @(posedge i_clk_sys);
    o_shift_clock_n <= 1'b0; // one shared fall for all lanes
    repeat (4 + slow) @(posedge i_clk_sys);
    o_serial        <= ~w; // hold over: show the inverse, not the old bit
    o_shift_clock_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== verification/mlsr_top_tb.sv ====
// self-checking testbench for the multi-lane shift register
`timescale 1ns/1ps
`default_nettype none
module mlsr_top_tb;
  logic       clk_sys;
  logic       rst;
  logic       shift_hold;
  logic       shift_clock_n;
  logic [3:0] serial;
  logic [5:0] taps;
  logic       sample_ready;
  logic [3:0] ea;
  logic [3:0] eb;
  logic [4:0] ec;
  logic [4:0] ed;
  logic [3:0] held[$];
  int         bad_count;
  int         check_count;

  // ************************************************************
  // design and system-side model
  // ************************************************************
  mlsr_top u_mlsr_top (
    .i_clk_sys          (clk_sys),
    .i_rst              (rst),
    .i_shift_clock_n    (shift_clock_n),
    .i_lane_a_serial_in (serial[0]),
    .i_lane_b_serial_in (serial[1]),
    .i_lane_c_serial_in (serial[2]),
    .i_lane_d_serial_in (serial[3]),
    .i_shift_hold       (shift_hold),
    .o_lane_a_last_out  (taps[0]),
    .o_lane_b_last_out  (taps[1]),
    .o_lane_c_fourth_tap(taps[2]),
    .o_lane_c_fifth_tap (taps[3]),
    .o_lane_d_fourth_tap(taps[4]),
    .o_lane_d_fifth_tap (taps[5]),
    .o_sample_ready     (sample_ready)
  );
  mlsr_sys_driver u_mlsr_sys_driver (
    .i_clk_sys      (clk_sys),
    .o_shift_clock_n(shift_clock_n),
    .o_serial       (serial)
  );

  // ************************************************************
  // reference lanes and comparison
  // ************************************************************
  // first stage in bit 0, each word bit feeds its own lane
  task automatic advance(input logic [3:0] w);
    ea = {ea[2:0], w[0]};
    eb = {eb[2:0], w[1]};
    ec = {ec[3:0], w[2]};
    ed = {ed[3:0], w[3]};
  endtask

  task automatic check(input string nm, input logic [5:0] seen,
                       input logic [5:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // taps are sampled clear of the clock edge
  task automatic check_taps(input string nm);
    #1;
    check(nm, taps, {ed[4], ed[3], ec[4], ec[3], eb[3], ea[3]});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // walking words through all lanes, one compare per shift
  task automatic test_flush;
    for (int i = 0; i < 10; i++) begin
      u_mlsr_sys_driver.shift_word(4'h9 ^ i[3:0], (i == 7) ? 6 : 0);
      advance(4'h9 ^ i[3:0]);
      check_taps("taps after shift");
    end
    $display("test flush done");
  endtask

  // reset in mid-run clears taps and closes the buffer
  task automatic test_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    {ea, eb, ec, ed} = 18'h0_0000;
    check_taps("taps in reset");
    check("ready in reset", {5'h0_0, sample_ready}, 6'h0_0);
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("ready after reset", {5'h0_0, sample_ready}, 6'h0_1);
    $display("test reset done");
  endtask

  // stall: 16 samples queue, the 17th is lost, then all drain
  task automatic test_hold;
    @(posedge clk_sys);
    shift_hold <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      u_mlsr_sys_driver.shift_word(i[3:0], 0);
      if (i < 16) held.push_back(i[3:0]);
      check_taps("taps frozen");
    end
    check("ready when full", {5'h0_0, sample_ready}, 6'h0_0);
    @(posedge clk_sys);
    shift_hold <= 1'b0;
    repeat (40) @(posedge clk_sys);
    while (held.size() > 0) advance(held.pop_front());
    check_taps("taps after drain");
    $display("test hold done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end

  initial begin
    rst         = 1'b1;
    shift_hold  = 1'b0;
    bad_count   = 0;
    check_count = 0;
    {ea, eb, ec, ed} = 18'h0_0000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    test_flush();
    test_reset();
    test_hold();
    conclude();
  end
endmodule
`default_nettype wire
